// file: src/avagc_core.sv
// What this block does
// RULE1 - separate volume per channel, -12 to +20 dB
// RULE2 - volume is 7-bit signed half-dB count
// RULE3 - ramp 1 or 2 steps/sample, or jump
// RULE4 - power-down ramps volume to -12 dB first
// RULE5 - volume-reached flags at status bits 7, 3
// RULE6 - fine trim 0 to -0.4 dB, 0.1 dB steps
// RULE7 - AGC drives PGA gain, once per sample
// RULE8 - level is averaged absolute output value
// RULE9 - eight target levels, -5.5 to -24 dBFS
// RULE10 - above target: lower gain at attack rate
// RULE11 - below target: raise gain at decay rate
// RULE12 - noise: ramp to 0 dB, flag, hold
// RULE13 - noise threshold -30 to -90 dBFS
// RULE14 - noise detection can be switched off
// RULE15 - software sets max gain for low thresholds
// RULE16 - AGC gain capped by programmable maximum
// RULE17 - noise/signal decision uses optional hysteresis
// RULE18 - noise declared after noise debounce; no raise
// RULE19 - raise resumes after signal debounce time
// RULE20 - read-only noise flag per channel
// RULE21 - read-only AGC applied gain per channel
// RULE22 - first-order level filter, 16-bit coefficients
// RULE23 - sticky saturation flag when max gain blocks
// RULE24 - volume and trim multiply, saturating output
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "avagc_defs.svh"
module avagc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire avagc_pkg::avagc_smp_s smp_in,
  output avagc_pkg::avagc_smp_s smp_out,
  output logic [6:0] pga_gain_l,
  output logic [6:0] pga_gain_r,
  output logic [1:0] ch_active
);
  import avagc_pkg::*;

  function automatic logic [15:0] mant(input logic [3:0] r);
    case (r)
      4'h0: mant = 16'h4000;
      4'h1: mant = 16'h43cb;
      4'h2: mant = 16'h47cf;
      4'h3: mant = 16'h4c10;
      4'h4: mant = 16'h5092;
      4'h5: mant = 16'h5559;
      4'h6: mant = 16'h5a67;
      4'h7: mant = 16'h5fc3;
      4'h8: mant = 16'h656f;
      4'h9: mant = 16'h6b72;
      4'ha: mant = 16'h71cf;
      default: mant = 16'h788e;
    endcase
  endfunction

  function automatic logic [15:0] att(input logic [3:0] r);
    case (r)
      4'h0: att = 16'h7fff;
      4'h1: att = 16'h78d6;
      4'h2: att = 16'h7214;
      4'h3: att = 16'h6bb3;
      4'h4: att = 16'h65ac;
      4'h5: att = 16'h5ffc;
      4'h6: att = 16'h5a9d;
      4'h7: att = 16'h558c;
      4'h8: att = 16'h50c3;
      4'h9: att = 16'h4c3f;
      4'ha: att = 16'h47fb;
      default: att = 16'h43f4;
    endcase
  endfunction

  // linear full-scale fraction for an attenuation in half-dB units
  function automatic logic [15:0] db2lin(input logic [7:0] a);
    logic [7:0] q;
    logic [7:0] r;
    q = a / `AV_OCTAVE;
    r = a % `AV_OCTAVE;
    db2lin = att(r[3:0]) >> q;
  endfunction

  function automatic logic [7:0] tgt_att(input logic [2:0] c);
    case (c)
      3'h0: tgt_att = 8'h0b;
      3'h1: tgt_att = 8'h10;
      3'h2: tgt_att = 8'h14;
      3'h3: tgt_att = 8'h18;
      3'h4: tgt_att = 8'h1c;
      3'h5: tgt_att = 8'h22;
      3'h6: tgt_att = 8'h28;
      default: tgt_att = 8'h30;
    endcase
  endfunction

  function automatic logic [15:0] trim_lin(input logic [2:0] k);
    case (k)
      3'h0: trim_lin = 16'h8000;
      3'h1: trim_lin = 16'h7e89;
      3'h2: trim_lin = 16'h7d16;
      3'h3: trim_lin = 16'h7ba8;
      default: trim_lin = 16'h7a3e;
    endcase
  endfunction

  // one soft-step toward tgt; ss[1] jumps, ss[0] picks two steps
  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt,
                                         input logic [1:0] ss);
    logic signed [7:0] d;
    logic signed [7:0] st;
    d = $signed(tgt) - $signed(cur);
    st = ss[0] ? 8'sh02 : 8'sh01;
    if (ss[1]) begin
      step_to = tgt;
    end else if (d > st) begin
      step_to = 8'(cur + st);
    end else if (d < -st) begin
      step_to = 8'(cur - st);
    end else begin
      step_to = tgt;
    end
  endfunction

  function automatic logic [7:0] cfg_byte(input avagc_cfg_s c, input logic [2:0] s,
                                          input logic [6:0] g);
    case (s)
      3'h0: cfg_byte = {c.en, c.target, 4'h0};
      3'h1: cfg_byte = {c.hyst, c.nthr, 1'b0};
      3'h2: cfg_byte = {1'b0, c.maxg};
      3'h3: cfg_byte = c.attack;
      3'h4: cfg_byte = c.decay;
      3'h5: cfg_byte = {3'h0, c.ndb};
      3'h6: cfg_byte = {4'h0, c.sdb};
      default: cfg_byte = {1'b0, g};
    endcase
  endfunction

  logic [7:0] idx;
  logic hit;
  logic wr;
  logic rd_status;
  logic [7:0] sub [2];
  logic [7:0] csub;
  logic [1:0] soft_step;
  logic [7:0] trim_reg;
  logic [6:0] vol_reg [2];
  logic [6:0] pga_man [2];
  logic [1:0] pwr;
  avagc_cfg_s cfg [2];
  logic [15:0] coef [3];
  logic [1:0][6:0] vol_all;
  logic [1:0][6:0] gain_all;
  logic [1:0][6:0] pga_all;
  logic [1:0][15:0] y_all;
  logic [1:0] vol_ok;
  logic [1:0] noise_flag;
  logic [1:0] sat_flag;

  assign idx = paddr[9:2];
  assign sub[0] = idx - `AV_IDX_AGC_L;
  assign sub[1] = idx - `AV_IDX_AGC_R;
  assign csub = idx - `AV_IDX_COEF;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr = psel & penable & pwrite & hit;
  assign rd_status = psel & penable & ~pwrite & hit & (idx == `AV_IDX_STATUS);

  always_comb begin
    prdata = '0;
    hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (idx)
      `AV_IDX_POWER: prdata[1:0] = pwr;
      `AV_IDX_STATUS: begin
        prdata[`AV_BIT_VOK_L] = vol_ok[0]; // RULE5
        prdata[`AV_BIT_VOK_R] = vol_ok[1]; // RULE5
        prdata[`AV_BIT_SAT_L] = sat_flag[0]; // RULE23
        prdata[`AV_BIT_SAT_R] = sat_flag[1];
      end
      `AV_IDX_AGC_STAT: begin
        prdata[`AV_BIT_NOISE_L] = noise_flag[0]; // RULE20
        prdata[`AV_BIT_NOISE_R] = noise_flag[1];
        prdata[`AV_BIT_ACT_L] = ch_active[0];
        prdata[`AV_BIT_ACT_R] = ch_active[1];
      end
      `AV_IDX_PGA_L: prdata[6:0] = pga_man[0];
      `AV_IDX_PGA_R: prdata[6:0] = pga_man[1];
      `AV_IDX_SOFTSTEP: prdata[1:0] = soft_step;
      `AV_IDX_TRIM: prdata[7:0] = trim_reg;
      `AV_IDX_VOL_L: prdata[6:0] = vol_reg[0];
      `AV_IDX_VOL_R: prdata[6:0] = vol_reg[1];
      default: begin
        if (sub[0] < `AV_AGC_REGS) begin
          prdata[7:0] = cfg_byte(cfg[0], sub[0][2:0], gain_all[0]); // RULE21
        end else if (sub[1] < `AV_AGC_REGS) begin
          prdata[7:0] = cfg_byte(cfg[1], sub[1][2:0], gain_all[1]); // RULE21
        end else if (csub < `AV_COEF_REGS) begin
          prdata[7:0] = csub[0] ? coef[csub[2:1]][7:0] : coef[csub[2:1]][15:8];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    // refused accesses read back zero
    if (!hit) begin
      prdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_step <= `AV_SS_RST;
      trim_reg <= '0;
      pwr <= '0;
      vol_reg[0] <= `AV_VOL_RST; // RULE2
      vol_reg[1] <= `AV_VOL_RST;
      pga_man[0] <= '0;
      pga_man[1] <= '0;
    end else if (wr) begin
      case (idx)
        `AV_IDX_POWER: pwr <= pwdata[1:0];
        `AV_IDX_SOFTSTEP: soft_step <= pwdata[1:0];
        `AV_IDX_TRIM: trim_reg <= pwdata[7:0];
        `AV_IDX_VOL_L: vol_reg[0] <= pwdata[6:0]; // RULE1
        `AV_IDX_VOL_R: vol_reg[1] <= pwdata[6:0]; // RULE1
        `AV_IDX_PGA_L: pga_man[0] <= pwdata[6:0];
        `AV_IDX_PGA_R: pga_man[1] <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg[0] <= '0;
      cfg[1] <= '0;
    end else if (wr) begin
      for (int c = 0; c < 2; c++) begin
        if (sub[c] < `AV_AGC_REGS) begin
          case (sub[c][2:0])
            3'h0: begin
              cfg[c].en <= pwdata[7];
              cfg[c].target <= pwdata[6:4]; // RULE9
            end
            3'h1: begin
              cfg[c].hyst <= pwdata[7:6]; // RULE17
              cfg[c].nthr <= pwdata[5:1]; // RULE13
            end
            3'h2: cfg[c].maxg <= pwdata[6:0]; // RULE16
            3'h3: cfg[c].attack <= pwdata[7:0];
            3'h4: cfg[c].decay <= pwdata[7:0];
            3'h5: cfg[c].ndb <= pwdata[4:0];
            3'h6: cfg[c].sdb <= pwdata[3:0];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coef[0] <= `AV_N0_RST;
      coef[1] <= `AV_N1_RST;
      coef[2] <= `AV_D1_RST;
    end else if (wr && csub < `AV_COEF_REGS) begin
      if (csub[0]) begin
        coef[csub[2:1]][7:0] <= pwdata[7:0]; // RULE22
      end else begin
        coef[csub[2:1]][15:8] <= pwdata[7:0]; // RULE22
      end
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [15:0] x;
    logic [6:0] vol_app;
    logic [6:0] pga_app;
    logic [6:0] agc_gain;
    avagc_state_e nstate;
    logic [4:0] dcnt;
    logic [7:0] tcnt;
    logic signed [16:0] ax1;
    logic signed [17:0] lev;
    logic sat;
    logic [2:0] k;
    logic [6:0] a7;
    logic signed [47:0] prod;
    logic signed [52:0] wide;
    logic signed [21:0] yw;
    logic signed [15:0] y;
    logic signed [16:0] ax;
    logic signed [35:0] acc;
    logic [7:0] na;
    logic [7:0] hh;
    logic signed [17:0] tgt_lin;
    logic signed [17:0] thr_mid;
    logic signed [17:0] thr_lo;
    logic signed [17:0] thr_hi;
    logic noise_en;
    logic [6:0] vol_tgt;
    logic [6:0] pga_tgt;
    logic [7:0] lim;

    assign x = (ch == 0) ? smp_in.left : smp_in.right;
    assign k = (ch == 0) ? trim_reg[6:4] : trim_reg[2:0];
    assign vol_tgt = pwr[ch] ? vol_reg[ch] : `AV_VOL_MIN; // RULE4
    // manual setting clamped to the analog range of 0 to 40 dB
    assign pga_tgt = cfg[ch].en ? agc_gain : // RULE7
                     ((pga_man[ch] > `AV_PGA_MAX) ? `AV_PGA_MAX : pga_man[ch]);
    assign a7 = vol_app + `AV_VOL_BIAS;
    assign noise_en = cfg[ch].nthr != '0; // RULE14
    assign na = `AV_NTHR_BASE + {1'b0, cfg[ch].nthr, 2'b00}; // RULE13
    assign lim = {1'b0, cfg[ch].maxg};

    always_comb begin
      case (cfg[ch].hyst)
        2'h0: hh = 8'h00;
        2'h1: hh = 8'h02;
        2'h2: hh = 8'h04;
        default: hh = 8'h08;
      endcase
      tgt_lin = {2'b00, db2lin(tgt_att(cfg[ch].target))}; // RULE9
      thr_mid = {2'b00, db2lin(na)};
      thr_lo = {2'b00, db2lin(8'(na + hh))}; // RULE17
      thr_hi = {2'b00, db2lin(8'(na - hh))}; // RULE17
      // gain = mant * 2^octave / 4 * trim, scaled back by the shift
      prod = x * $signed({1'b0, mant(4'(a7 % `AV_OCTAVE))})
           * $signed({1'b0, trim_lin((k > `AV_TRIM_MAX) ? `AV_TRIM_MAX : k)}); // RULE6
      wide = 53'(prod) <<< (a7 / `AV_OCTAVE);
      yw = 22'(wide >>> `AV_GAIN_SHIFT);
      if (yw > 22'sh007fff) begin
        y = 16'sh7fff; // RULE24
      end else if (yw < -22'sh008000) begin
        y = -16'sh8000; // RULE24
      end else begin
        y = yw[15:0];
      end
      ax = y[15] ? -17'(y) : 17'(y); // RULE8
      acc = $signed(coef[0]) * ax + $signed(coef[1]) * ax1 + $signed(coef[2]) * lev; // RULE22
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vol_app <= `AV_VOL_RST;
      end else if (smp_in.valid) begin
        vol_app <= 7'(step_to({vol_app[6], vol_app}, {vol_tgt[6], vol_tgt}, soft_step)); // RULE3
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pga_app <= '0;
      end else if (smp_in.valid) begin
        pga_app <= 7'(step_to({1'b0, pga_app}, {1'b0, pga_tgt}, soft_step)); // RULE3
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ax1 <= '0;
        lev <= '0;
      end else if (smp_in.valid) begin
        ax1 <= ax;
        lev <= 18'(acc >>> `AV_COEF_SHIFT); // RULE8
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        nstate <= AVAGC_SIGNAL;
        dcnt <= '0;
      end else if (smp_in.valid) begin
        case (nstate)
          AVAGC_SIGNAL: begin
            if (noise_en && lev < thr_lo) begin
              if (dcnt >= cfg[ch].ndb) begin
                nstate <= AVAGC_NOISE; // RULE18
                dcnt <= '0;
              end else begin
                dcnt <= dcnt + 5'h01;
              end
            end else begin
              dcnt <= '0;
            end
          end
          AVAGC_NOISE: begin
            if (!noise_en) begin
              nstate <= AVAGC_SIGNAL; // RULE14
              dcnt <= '0;
            end else if (lev > thr_hi) begin
              if (dcnt >= {1'b0, cfg[ch].sdb}) begin
                nstate <= AVAGC_SIGNAL; // RULE19
                dcnt <= '0;
              end else begin
                dcnt <= dcnt + 5'h01;
              end
            end else begin
              dcnt <= '0;
            end
          end
          default: nstate <= AVAGC_SIGNAL;
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        agc_gain <= '0;
        tcnt <= '0;
        sat <= 1'b0;
      end else begin
        if (rd_status) begin
          sat <= 1'b0;
        end
        if (smp_in.valid) begin
          if (!cfg[ch].en) begin
            agc_gain <= pga_app;
            tcnt <= '0;
          end else if (nstate == AVAGC_NOISE) begin
            agc_gain <= (agc_gain != '0) ? agc_gain - 7'h01 : '0; // RULE12
            tcnt <= '0;
          end else if ({1'b0, agc_gain} > lim) begin
            agc_gain <= cfg[ch].maxg; // RULE16
          end else if (lev > tgt_lin) begin
            tcnt <= (tcnt >= cfg[ch].attack) ? '0 : tcnt + 8'h01;
            if (tcnt >= cfg[ch].attack && agc_gain != '0) begin
              agc_gain <= agc_gain - 7'h01; // RULE10
            end
          end else if (lev < tgt_lin && !(noise_en && lev < thr_mid)) begin // RULE18
            tcnt <= (tcnt >= cfg[ch].decay) ? '0 : tcnt + 8'h01;
            if (tcnt >= cfg[ch].decay) begin
              if ({1'b0, agc_gain} < lim && agc_gain < `AV_PGA_MAX) begin
                agc_gain <= agc_gain + 7'h01; // RULE11
              end else begin
                sat <= 1'b1; // RULE23
              end
            end
          end else begin
            tcnt <= '0;
          end
        end
      end
    end

    assign vol_all[ch] = vol_app;
    assign gain_all[ch] = agc_gain;
    assign pga_all[ch] = pga_app;
    assign y_all[ch] = y;
    assign vol_ok[ch] = vol_app == vol_reg[ch]; // RULE5
    assign noise_flag[ch] = nstate == AVAGC_NOISE; // RULE20
    assign sat_flag[ch] = sat;
    assign ch_active[ch] = pwr[ch] | (vol_app != `AV_VOL_MIN); // RULE4
  end

  assign pga_gain_l = pga_all[0];
  assign pga_gain_r = pga_all[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_out <= '0;
    end else begin
      smp_out.valid <= smp_in.valid;
      if (smp_in.valid) begin
        smp_out.left <= y_all[0]; // RULE24
        smp_out.right <= y_all[1];
      end
    end
  end
endmodule

// file: src/avagc_defs.svh
`ifndef AVAGC_DEFS_SVH
`define AVAGC_DEFS_SVH
// register indices; byte address is four times the index
`define AV_IDX_POWER 8'h13
`define AV_IDX_STATUS 8'h24
`define AV_IDX_AGC_STAT 8'h2f
`define AV_IDX_PGA_L 8'h3b
`define AV_IDX_PGA_R 8'h3c
`define AV_IDX_SOFTSTEP 8'h51
`define AV_IDX_TRIM 8'h52
`define AV_IDX_VOL_L 8'h53
`define AV_IDX_VOL_R 8'h54
`define AV_IDX_AGC_L 8'h56
`define AV_IDX_AGC_R 8'h5e
`define AV_IDX_COEF 8'h66
`define AV_AGC_REGS 8'h08
`define AV_COEF_REGS 8'h06
// bit positions
`define AV_BIT_VOK_L 7
`define AV_BIT_SAT_L 5
`define AV_BIT_VOK_R 3
`define AV_BIT_SAT_R 1
`define AV_BIT_NOISE_L 6
`define AV_BIT_NOISE_R 5
`define AV_BIT_ACT_L 1
`define AV_BIT_ACT_R 0
// values
`define AV_VOL_RST 7'h00
`define AV_VOL_MIN 7'h68
`define AV_VOL_MAX 7'h28
`define AV_VOL_BIAS 7'h18
`define AV_PGA_MAX 7'h50
`define AV_TRIM_MAX 3'h4
`define AV_SS_RST 2'h0
`define AV_N0_RST 16'h0080
`define AV_N1_RST 16'h0080
`define AV_D1_RST 16'h7f00
`define AV_COEF_SHIFT 15
`define AV_GAIN_SHIFT 31
`define AV_NTHR_BASE 8'h38
`define AV_OCTAVE 8'h0c
`endif

// file: src/avagc_pkg.sv
package avagc_pkg;
  typedef struct packed {
    logic en;
    logic [2:0] target;
    logic [1:0] hyst;
    logic [4:0] nthr;
    logic [6:0] maxg;
    logic [7:0] attack;
    logic [7:0] decay;
    logic [4:0] ndb;
    logic [3:0] sdb;
  } avagc_cfg_s;
  typedef struct packed {
    logic valid;
    logic signed [15:0] left;
    logic signed [15:0] right;
  } avagc_smp_s;
  typedef enum logic {AVAGC_SIGNAL, AVAGC_NOISE} avagc_state_e;
endpackage

// file: verif/avagc_monitor.sv
`timescale 1ns/100ps
module avagc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire avagc_pkg::avagc_smp_s smp_in,
  input wire avagc_pkg::avagc_smp_s smp_out,
  input wire logic [6:0] pga_gain_l,
  input wire logic [6:0] pga_gain_r,
  input wire logic [1:0] ch_active
);
  import avagc_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_valid_follow: assert property (smp_in.valid |=> smp_out.valid)
    else $error("no output sample after input sample");
  a_valid_only: assert property (!smp_in.valid |=> !smp_out.valid)
    else $error("stray output sample");
  a_data_hold: assert property (
    !smp_in.valid |=> $stable(smp_out.left) && $stable(smp_out.right))
    else $error("output data changed between samples");
  a_gain_per_sample: assert property (
    !smp_in.valid |=> $stable(pga_gain_l) && $stable(pga_gain_r))
    else $error("pga gain moved without a sample");
  a_pga_ceiling: assert property (pga_gain_l <= 7'h50 && pga_gain_r <= 7'h50)
    else $error("pga gain above 40 dB");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_err_data: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule
bind avagc_core avagc_monitor avagc_monitor_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_in(smp_in),
  .smp_out(smp_out), .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r),
  .ch_active(ch_active));

// file: verif/test_adc_volume_and_agc.sv
`timescale 1ns/100ps
`include "avagc_defs.svh"
module test_adc_volume_and_agc;
  import avagc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  avagc_smp_s smp_in = '0;
  avagc_smp_s smp_out;
  logic [6:0] pga_gain_l;
  logic [6:0] pga_gain_r;
  logic [1:0] ch_active;
  logic [31:0] rd;
  logic err;
  logic [7:0] agc_cfg [7] = '{8'hb0, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  int num_errors = 0;
  int num_checks = 0;
  always #12.5 pclk = ~pclk;
  avagc_core avagc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_in(smp_in),
    .smp_out(smp_out), .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r),
    .ch_active(ch_active));
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task check_eq(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_rng(input logic signed [15:0] got, input logic signed [15:0] lo,
                 input logic signed [15:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic logic [11:0] a(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // one apb transfer; holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, a(i), d);
  endtask
  task rdchk(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a(i), 8'h00);
    check_eq(rd & {24'h0, m}, {24'h0, e});
  endtask
  task smp(input int n, input logic [15:0] l, input logic [15:0] r);
    repeat (n) begin
      @(posedge pclk);
      smp_in <= {1'b1, l, r};
      @(posedge pclk);
      smp_in <= {1'b0, l, r};
    end
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`AV_IDX_VOL_L, 8'h7f, 8'h00);
    rdchk(`AV_IDX_VOL_R, 8'h7f, 8'h00);
    rdchk(`AV_IDX_SOFTSTEP, 8'h03, 8'h00);
    rdchk(`AV_IDX_TRIM, 8'h77, 8'h00);
    apb(1'b0, a(8'h00), 8'h00);
    check_eq({rd[30:0], err}, 32'h1);
    apb(1'b0, 12'h14d, 8'h00);
    check_eq({rd[30:0], err}, 32'h1);
    rdchk(8'(`AV_IDX_COEF + 1), 8'hff, 8'h80);
    wr(`AV_IDX_COEF, 8'h5a);
    rdchk(`AV_IDX_COEF, 8'hff, 8'h5a);
    wr(`AV_IDX_COEF, 8'h00);
    apb(1'b1, a(`AV_IDX_STATUS), 8'hff);
    check_eq({31'h0, err}, 32'h0);
    $display("test registers done");
    wr(`AV_IDX_POWER, 8'h03);
    wr(`AV_IDX_SOFTSTEP, 8'h02);
    wr(`AV_IDX_VOL_L, 8'h28);
    wr(`AV_IDX_VOL_R, 8'h68);
    rdchk(`AV_IDX_VOL_L, 8'h7f, 8'h28);
    wr(`AV_IDX_PGA_R, 8'h20);
    smp(2, 16'h7000, 16'h7000);
    check_eq(smp_out.left, 16'h7fff);
    check_rng(smp_out.right, 16'sh1800, 16'sh2000);
    check_eq(pga_gain_r, 7'h20);
    rdchk(`AV_IDX_STATUS, 8'h88, 8'h88);
    smp(1, 16'h9000, 16'h0000);
    check_eq({16'h0, smp_out.left}, 32'h8000);
    wr(`AV_IDX_VOL_R, 8'h00);
    wr(`AV_IDX_TRIM, 8'h04);
    smp(2, 16'h0000, 16'h4000);
    check_rng(smp_out.right, 16'sh3c00, 16'sh3fff);
    $display("test volume done");
    wr(`AV_IDX_SOFTSTEP, 8'h00);
    wr(`AV_IDX_VOL_L, 8'h68);
    smp(30, 16'h0000, 16'h0000);
    rdchk(`AV_IDX_STATUS, 8'h80, 8'h00);
    smp(40, 16'h0000, 16'h0000);
    rdchk(`AV_IDX_STATUS, 8'h80, 8'h80);
    wr(`AV_IDX_SOFTSTEP, 8'h01);
    wr(`AV_IDX_VOL_L, 8'h28);
    smp(20, 16'h0000, 16'h0000);
    rdchk(`AV_IDX_STATUS, 8'h80, 8'h00);
    smp(16, 16'h0000, 16'h0000);
    rdchk(`AV_IDX_STATUS, 8'h80, 8'h80);
    wr(`AV_IDX_SOFTSTEP, 8'h00);
    wr(`AV_IDX_POWER, 8'h02);
    smp(30, 16'h0000, 16'h0000);
    check_eq(ch_active, 2'b11);
    smp(40, 16'h0000, 16'h0000);
    check_eq(ch_active, 2'b10);
    wr(`AV_IDX_POWER, 8'h03);
    $display("test ramp done");
    for (int k = 0; k < 7; k++) begin
      wr(8'(`AV_IDX_AGC_L + k), agc_cfg[k]);
    end
    smp(40, 16'h0010, 16'h0000);
    check_eq(pga_gain_l, 7'h10);
    rdchk(8'(`AV_IDX_AGC_L + 7), 8'hff, 8'h10);
    rdchk(`AV_IDX_STATUS, 8'h20, 8'h20);
    wr(8'(`AV_IDX_AGC_L + 1), 8'h02);
    smp(40, 16'h0010, 16'h0000);
    check_eq(pga_gain_l, 7'h00);
    rdchk(`AV_IDX_AGC_STAT, 8'h40, 8'h40);
    wr(8'(`AV_IDX_AGC_L + 1), 8'h00);
    smp(40, 16'h0010, 16'h0000);
    check_eq(pga_gain_l, 7'h10);
    rdchk(`AV_IDX_AGC_STAT, 8'h40, 8'h00);
    smp(600, 16'h7fff, 16'h0000);
    check_eq(pga_gain_l, 7'h00);
    rdchk(`AV_IDX_STATUS, 8'h20, 8'h20);
    rdchk(`AV_IDX_STATUS, 8'h20, 8'h00);
    $display("test agc done");
    report_and_stop();
  end
endmodule
